// *** rtl/pss_defines.svh ***
// register map, field positions and reset values of the sleep select block
// included by the gating array, register slave, top and bench files; not by the package or interface
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH
`define PSS_WORD_W 16
`define PSS_SEL_ADDR 16'h9400
`define PSS_STATE_ADDR 16'h9401
`define PSS_SEL_RST 16'h0000
`define PSS_STATE_RST 16'h0000
`define PSS_RDATA_RST 16'h0000
`define PSS_SEL_WMASK 16'h3fff
`define PSS_GATE_MASK 16'h3fef
`define PSS_B_TIMER_ZERO_SLEEP 0
`define PSS_B_TIMER_ONE_SLEEP 1
`define PSS_B_SP0 2
`define PSS_B_SP1 3
`define PSS_B_GPIO 5
`define PSS_B_SIX 6
`define PSS_B_I2C 7
`define PSS_B_UART 8
`define PSS_B_PAR 9
`define PSS_B_WDOG 10
`define PSS_B_SYST 11
`define PSS_B_EXTERNAL_MEMORY_INTERFACE_SLEEP 12
`define PSS_B_MISC 13
`endif

// *** rtl/pss_gate.sv ***
// per-module sleep request and sleep state array
// clock-stop acks come from logic on clk, so they are not synchronised
`timescale 1ns/100ps
`include "pss_defines.svh"
module pss_gate (
  input wire logic clk,
  input wire logic rst_b,
  input wire pss_pkg::pss_word_type ack,
  output pss_pkg::pss_word_type req,
  pss_if.gate sl
);
  import pss_pkg::*;
  localparam pss_word_type GM = `PSS_GATE_MASK;
  pss_gate_type r;
  pss_gate_type n;
  pss_word_type req_n;
  pss_word_type st_n;
  for (genvar i = 0; i < `PSS_WORD_W; i++) begin : g_bit
    // wake overrides the selects; go re-evaluates every select bit that the gate mask keeps
    assign req_n[i] = GM[i] & (sl.wake ? 1'b0 :
      (sl.go ? sl.sel[i] : r.req[i]));
    // state follows the stopped clock, not the request alone
    assign st_n[i] = GM[i] & r.req[i] & ack[i];
  end
  always_comb begin
    n = r;
    n.req = req_n;
    n.state = st_n;
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r <= '{req: `PSS_STATE_RST, state: `PSS_STATE_RST};
    end else begin
      r <= n;
    end
  end
  assign req = r.req;
  assign sl.state = r.state;
endmodule

// *** rtl/pss_if.sv ***
// internal carrier between top, register slave and gating array
// all signals on clk, driven by exactly one modport
`timescale 1ns/100ps
interface pss_if;
  import pss_pkg::*;
  pss_word_type sel;
  pss_word_type state;
  logic go;
  logic wake;
  modport regs (output sel, input state);
  modport gate (input sel, input go, input wake, output state);
  modport ctl (input sel, input state, output go, output wake);
endinterface

// *** rtl/pss_pkg.sv ***
// types shared by the sleep select block
// no assumptions beyond a 16-bit peripheral data path
package pss_pkg;
  typedef logic [15:0] pss_word_type;
  typedef enum logic [0:0] {
    PSS_RUN = 1'b0,
    PSS_ASLEEP = 1'b1
  } pss_mode_type;
  typedef struct packed {
    pss_mode_type mode;
  } pss_ctl_type;
  typedef struct packed {
    pss_word_type sel;
    pss_word_type rdata;
  } pss_regs_type;
  typedef struct packed {
    pss_word_type req;
    pss_word_type state;
  } pss_gate_type;
endpackage

// *** rtl/pss_regs.sv ***
// register slave: select word and read-only state word
// master never issues read and write strobes together
`timescale 1ns/100ps
`include "pss_defines.svh"
module pss_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire pss_pkg::pss_word_type reg_addr,
  input wire pss_pkg::pss_word_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output pss_pkg::pss_word_type reg_rdata,
  pss_if.regs sl
);
  import pss_pkg::*;
  pss_regs_type r;
  pss_regs_type n;
  always_comb begin
    n = r;
    n.rdata = `PSS_RDATA_RST;
    if (reg_wr && reg_addr == `PSS_SEL_ADDR) begin
      n.sel = reg_wdata & `PSS_SEL_WMASK;
    end
    if (reg_rd && reg_addr == `PSS_SEL_ADDR) begin
      n.rdata = r.sel;
    end
    if (reg_rd && reg_addr == `PSS_STATE_ADDR) begin
      n.rdata = sl.state;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r <= '{sel: `PSS_SEL_RST, rdata: `PSS_RDATA_RST};
    end else begin
      r <= n;
    end
  end
  assign sl.sel = r.sel;
  assign reg_rdata = r.rdata;
endmodule

// *** rtl/pss_top.sv ***
// peripheral sleep select and status: idle sequencing and checks
// idle_exec, the group request and the acks are synchronous to clk
//
// Functional notes
// - select bit 8 set puts the uart to sleep on a group idle.
// - select bit 7 set puts the i2c controller to sleep.
// - select bit 6 set puts the bit-six module to sleep.
// - select bit 5 set puts the general pin port to sleep.
// - select bit 3 set puts serial port one to sleep.
// - select bit 2 set puts serial port zero to sleep.
// - select bit 1 set puts timer one to sleep.
// - select bit 0 set puts timer zero to sleep.
// - idle with group request low while asleep wakes everything.
// - idle while group flag high wakes modules whose select is 0.
// - state word at 9401 is read-only and resets to zero.
// - state bit 13 is the misc group; bits 15, 14, 4 read 0.
// - misc group covers bus, timeout, timer, clock-out, clock words.
// - state bit 12 shows the external memory interface asleep.
// - state bit 10 shows the watchdog asleep.
// - state bit 9 shows the parallel pin port asleep.
// - state bit 8 shows the uart asleep.
// - state bit 5 shows the general pin port asleep.
// - state bits 1 and 0 show timers one and zero asleep.
// - state bits 3 and 2 show serial ports one and zero asleep.
// - select word at 9400; bits 13 to 9 cover misc to parallel.
// - group flag is 1 while the peripheral group is asleep.
`timescale 1ns/100ps
`include "pss_defines.svh"
module pss_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire pss_pkg::pss_word_type reg_addr,
  input wire pss_pkg::pss_word_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output pss_pkg::pss_word_type reg_rdata,
  input wire logic idle_exec,
  input wire logic module_group_sleep_request,
  input wire pss_pkg::pss_word_type module_clock_stopped,
  output pss_pkg::pss_word_type module_sleep_req,
  output logic module_group_sleep_flag
);
  import pss_pkg::*;
  pss_if sl ();
  pss_ctl_type r;
  pss_ctl_type n;
  logic go;
  logic wake;

  // an idle with the request low does nothing unless the group sleeps
  assign go = idle_exec & module_group_sleep_request;
  assign wake = idle_exec & ~module_group_sleep_request &
    (r.mode == PSS_ASLEEP);

  always_comb begin
    n = r;
    unique case (r.mode)
      PSS_RUN: begin
        if (go) begin
          n.mode = PSS_ASLEEP;
        end
      end
      PSS_ASLEEP: begin
        if (wake) begin
          n.mode = PSS_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r <= '{mode: PSS_RUN};
    end else begin
      r <= n;
    end
  end

  assign sl.go = go;
  assign sl.wake = wake;
  assign module_group_sleep_flag = (r.mode == PSS_ASLEEP);

  pss_regs u_regs (
    .clk(clk),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .sl(sl)
  );

  // misc group (bit 13) gates all the bus and clock setup words as one
  pss_gate u_gate (
    .clk(clk),
    .rst_b(rst_b),
    .ack(module_clock_stopped),
    .req(module_sleep_req),
    .sl(sl)
  );

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_go;
    idle_exec && module_group_sleep_request;
  endsequence

  sequence s_wake;
    idle_exec && !module_group_sleep_request &&
      module_group_sleep_flag;
  endsequence

  sequence s_sel_rd;
    reg_rd && reg_addr == `PSS_SEL_ADDR;
  endsequence

  sequence s_st_rd;
    reg_rd && reg_addr == `PSS_STATE_ADDR;
  endsequence

  property p_sel_follow(int b);
    s_go |=> module_sleep_req[b] == $past(sl.sel[b]);
  endproperty

  property p_hold(int b);
    !idle_exec |=> $stable(module_sleep_req[b]);
  endproperty

  property p_state_bit(int b);
    ##1 sl.state[b] ==
      ($past(module_sleep_req[b]) && $past(module_clock_stopped[b]));
  endproperty

  chk_uart_sel_sleep: assert property (
    p_sel_follow(`PSS_B_UART))
    else $error("uart sleep request does not follow its select");

  chk_i2c_sel_sleep: assert property (
    p_sel_follow(`PSS_B_I2C))
    else $error("i2c sleep request does not follow its select");

  chk_six_sel_sleep: assert property (
    p_sel_follow(`PSS_B_SIX))
    else $error("bit-six sleep request does not follow its select");

  chk_gpio_sel_sleep: assert property (
    p_sel_follow(`PSS_B_GPIO))
    else $error("pin port sleep request does not follow its select");

  chk_sp1_sel_sleep: assert property (
    p_sel_follow(`PSS_B_SP1))
    else $error("serial one sleep request does not follow select");

  chk_sp0_sel_sleep: assert property (
    p_sel_follow(`PSS_B_SP0))
    else $error("serial zero sleep request does not follow select");

  chk_timer_one_sleep_sel_sleep: assert property (
    p_sel_follow(`PSS_B_TIMER_ONE_SLEEP))
    else $error("timer one sleep request does not follow select");

  chk_timer_zero_sleep_sel_sleep: assert property (
    p_sel_follow(`PSS_B_TIMER_ZERO_SLEEP))
    else $error("timer zero sleep request does not follow select");

  chk_uart_req_hold: assert property (
    p_hold(`PSS_B_UART))
    else $error("uart sleep request moved without an idle");

  chk_timer_zero_sleep_req_hold: assert property (
    p_hold(`PSS_B_TIMER_ZERO_SLEEP))
    else $error("timer zero sleep request moved without an idle");

  chk_i2c_req_hold: assert property (
    p_hold(`PSS_B_I2C))
    else $error("i2c sleep request moved without an idle");

  chk_six_req_hold: assert property (
    p_hold(`PSS_B_SIX))
    else $error("bit-six sleep request moved without an idle");

  chk_gpio_req_hold: assert property (
    p_hold(`PSS_B_GPIO))
    else $error("pin port sleep request moved without an idle");

  chk_sp1_req_hold: assert property (
    p_hold(`PSS_B_SP1))
    else $error("serial one sleep request moved without an idle");

  chk_sp0_req_hold: assert property (
    p_hold(`PSS_B_SP0))
    else $error("serial zero sleep request moved without an idle");

  chk_timer_one_sleep_req_hold: assert property (
    p_hold(`PSS_B_TIMER_ONE_SLEEP))
    else $error("timer one sleep request moved without an idle");

  chk_par_req_hold: assert property (
    p_hold(`PSS_B_PAR))
    else $error("parallel sleep request moved without an idle");

  chk_wdog_req_hold: assert property (
    p_hold(`PSS_B_WDOG))
    else $error("watchdog sleep request moved without an idle");

  chk_syst_req_hold: assert property (
    p_hold(`PSS_B_SYST))
    else $error("system timer sleep request moved without an idle");

  chk_external_memory_interface_sleep_req_hold: assert property (
    p_hold(`PSS_B_EXTERNAL_MEMORY_INTERFACE_SLEEP))
    else $error("memory if sleep request moved without an idle");

  chk_misc_req_hold: assert property (
    p_hold(`PSS_B_MISC))
    else $error("misc group sleep request moved without an idle");

  chk_wake_all_idle: assert property (
    s_wake |=> (module_sleep_req == `PSS_STATE_RST) &&
      !module_group_sleep_flag ##1
      (sl.state == `PSS_STATE_RST))
    else $error("idle with request low did not wake every module");

  chk_wake_unselected: assert property (
    module_group_sleep_flag && idle_exec |=>
      (module_sleep_req & ~$past(sl.sel)) == `PSS_STATE_RST)
    else $error("module with select 0 still asleep after idle");

  chk_state_read: assert property (
    s_st_rd |=> reg_rdata == $past(sl.state))
    else $error("state word read does not show the module state");

  chk_state_ro: assert property (
    reg_wr && reg_addr == `PSS_STATE_ADDR |=>
      sl.state == ($past(module_sleep_req) &
        $past(module_clock_stopped) & `PSS_GATE_MASK))
    else $error("write to state word changed the state");

  chk_rsvd_zero: assert property (
    s_st_rd |=> reg_rdata[15:14] == 2'h0 && !reg_rdata[4])
    else $error("reserved state bits read non-zero");

  chk_misc_state: assert property (
    p_state_bit(`PSS_B_MISC))
    else $error("misc group state bit wrong");

  chk_external_memory_interface_sleep_state: assert property (
    p_state_bit(`PSS_B_EXTERNAL_MEMORY_INTERFACE_SLEEP))
    else $error("memory interface state bit wrong");

  chk_wdog_state: assert property (
    p_state_bit(`PSS_B_WDOG))
    else $error("watchdog state bit wrong");

  chk_par_state: assert property (
    p_state_bit(`PSS_B_PAR))
    else $error("parallel port state bit wrong");

  chk_uart_state: assert property (
    p_state_bit(`PSS_B_UART))
    else $error("uart state bit wrong");

  chk_gpio_state: assert property (
    p_state_bit(`PSS_B_GPIO))
    else $error("general pin port state bit wrong");

  chk_timer_one_sleep_state: assert property (
    p_state_bit(`PSS_B_TIMER_ONE_SLEEP))
    else $error("timer one state bit wrong");

  chk_timer_zero_sleep_state: assert property (
    p_state_bit(`PSS_B_TIMER_ZERO_SLEEP))
    else $error("timer zero state bit wrong");

  chk_sp1_state: assert property (
    p_state_bit(`PSS_B_SP1))
    else $error("serial one state bit wrong");

  chk_sp0_state: assert property (
    p_state_bit(`PSS_B_SP0))
    else $error("serial zero state bit wrong");

  chk_i2c_state: assert property (
    p_state_bit(`PSS_B_I2C))
    else $error("i2c state bit wrong");

  chk_six_state: assert property (
    p_state_bit(`PSS_B_SIX))
    else $error("bit-six state bit wrong");

  chk_syst_state: assert property (
    p_state_bit(`PSS_B_SYST))
    else $error("system timer state bit wrong");

  chk_state_rsvd: assert property (
    ##1 sl.state[15:14] == 2'h0 && !sl.state[4])
    else $error("reserved state bits set");

  chk_sel_readback: assert property (
    reg_wr && reg_addr == `PSS_SEL_ADDR ##1 s_sel_rd |=>
      reg_rdata == ($past(reg_wdata, 2) & `PSS_SEL_WMASK))
    else $error("select word does not read back what was written");

  chk_sel_upper: assert property (
    s_go |=> module_sleep_req[13:9] == $past(sl.sel[13:9]))
    else $error("upper select bits not applied on group idle");

  chk_flag_rise: assert property (
    $rose(module_group_sleep_flag) |-> $past(idle_exec) &&
      $past(module_group_sleep_request))
    else $error("group flag rose without an idle with request");

  chk_flag_fall: assert property (
    $fell(module_group_sleep_flag) |-> $past(idle_exec) &&
      !$past(module_group_sleep_request))
    else $error("group flag fell without a waking idle");

  chk_flag_set: assert property (
    s_go |=> module_group_sleep_flag [*1] ##0
      (module_sleep_req == ($past(sl.sel) & `PSS_GATE_MASK)))
    else $error("idle with request did not enter group sleep");

  chk_state_ack: assert property (
    ##1 (sl.state & ~$past(module_clock_stopped)) ==
      `PSS_STATE_RST)
    else $error("state bit set while module clock still runs");

  chk_state_wake: assert property (
    ##1 (sl.state & ~$past(module_sleep_req)) == `PSS_STATE_RST)
    else $error("state bit still set after module woke");

  chk_unmapped_zero: assert property (
    reg_rd && reg_addr != `PSS_SEL_ADDR &&
      reg_addr != `PSS_STATE_ADDR |=> reg_rdata == `PSS_RDATA_RST)
    else $error("unmapped read returned non-zero data");

  chk_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == `PSS_RDATA_RST)
    else $error("read data present without a read");
endmodule

// *** tb/test_peripheral_sleep_select_status.sv ***
// self-checking bench for the peripheral sleep select and status block
// drives pss_top ports directly; the bench plays the processor and the acks
`timescale 1ns/100ps
`include "pss_defines.svh"
module test_peripheral_sleep_select_status;
  import pss_pkg::*;
  logic clk;
  logic rst_b;
  logic reg_wr;
  logic reg_rd;
  logic idle_exec;
  logic grp_req;
  logic gflag;
  pss_word_type reg_addr;
  pss_word_type reg_wdata;
  pss_word_type reg_rdata;
  pss_word_type ack;
  pss_word_type sreq;
  pss_word_type m;
  int err_count;
  int n_checks;
  int bits [13] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 10, 11, 12, 13};

  pss_top DUT (
    .clk(clk),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .idle_exec(idle_exec),
    .module_group_sleep_request(grp_req),
    .module_clock_stopped(ack),
    .module_sleep_req(sreq),
    .module_group_sleep_flag(gflag)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input pss_word_type got, input pss_word_type exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one-cycle write strobe, released on the edge that takes it
  task automatic wr(input pss_word_type a, input pss_word_type d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input pss_word_type a, input pss_word_type exp,
                        input string what);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, what);
  endtask

  task automatic idle(input logic r);
    @(posedge clk);
    idle_exec <= 1'b1;
    grp_req <= r;
    @(posedge clk);
    idle_exec <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("BAD %0t timeout", $time);
    wrap_up();
  end

  initial begin
    err_count = 0;
    n_checks = 0;
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    idle_exec = 1'b0;
    grp_req = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    ack = 16'h0000;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk(sreq, 16'h0000, "req after reset");
    chk({15'h0000, gflag}, 16'h0000, "flag after reset");
    rd_chk(`PSS_SEL_ADDR, 16'h0000, "select reset");
    rd_chk(`PSS_STATE_ADDR, 16'h0000, "state reset");
    wr(`PSS_SEL_ADDR, 16'hffff);
    rd_chk(`PSS_SEL_ADDR, 16'h3fff, "select top bits");
    wr(`PSS_STATE_ADDR, 16'hffff);
    rd_chk(`PSS_STATE_ADDR, 16'h0000, "state write ignored");
    rd_chk(16'h9402, 16'h0000, "unmapped read");
    // acks alone, with nothing requested, must not show as asleep
    @(posedge clk);
    ack <= 16'hffff;
    idle(1'b0);
    chk({15'h0000, gflag}, 16'h0000, "idle while awake");
    rd_chk(`PSS_STATE_ADDR, 16'h0000, "ack without req");
    idle(1'b1);
    chk(sreq, 16'h3fef, "all selected");
    chk({15'h0000, gflag}, 16'h0001, "flag asleep");
    rd_chk(`PSS_STATE_ADDR, 16'h3fef, "state all");
    @(posedge clk);
    ack <= 16'hfeff;
    rd_chk(`PSS_STATE_ADDR, 16'h3eef, "ack dropped");
    @(posedge clk);
    ack <= 16'hffff;
    // a select change takes effect only at the next idle
    wr(`PSS_SEL_ADDR, 16'h0100);
    chk(sreq, 16'h3fef, "select alone");
    idle(1'b1);
    chk(sreq, 16'h0100, "unselected wake");
    rd_chk(`PSS_STATE_ADDR, 16'h0100, "state partial");
    wr(`PSS_SEL_ADDR, 16'h3fff);
    idle(1'b0);
    chk(sreq, 16'h0000, "wake all");
    chk({15'h0000, gflag}, 16'h0000, "flag awake");
    rd_chk(`PSS_STATE_ADDR, 16'h0000, "state woke");
    foreach (bits[i]) begin
      m = 16'h0001 << bits[i];
      wr(`PSS_SEL_ADDR, m);
      idle(1'b1);
      chk(sreq, m, "single select");
      chk(sreq, m, "single select again");
      rd_chk(`PSS_STATE_ADDR, m, "single state");
      rd_chk(`PSS_STATE_ADDR, m, "single state");
      idle(1'b0);
      chk(sreq, 16'h0000, "single wake");
    end
    // bit 4 stores but gates nothing
    wr(`PSS_SEL_ADDR, 16'h0010);
    rd_chk(`PSS_SEL_ADDR, 16'h0010, "bit four stored");
    idle(1'b1);
    chk(sreq, 16'h0000, "bit four gates nothing");
    rd_chk(`PSS_STATE_ADDR, 16'h0000, "bit four state");
    wrap_up();
  end
endmodule
